/* File: drf_defines.svh */
// Constants of the DRAM timing and refresh flag block
//
// Operation
// [RQ1] Row-to-column wait: codes 00..11 add 0..3
// [RQ2] Software writes zero to reserved timing bits
// [RQ3] Suspend enable stretches single-address DMA reads
// [RQ4] Extension codes 00..11 insert 1..4 states
// [RQ5] Extension field ignored unless suspend enabled
// [RQ6] Counter equals compare value sets flag
// [RQ7] Timer mode: flag cleared by write-zero-after-read
// [RQ8] Refresh mode: refresh cycle clears the flag
// [RQ9] Interrupt enable gates the flag request
// [RQ10] Refresh enable selects refresh or interval timer
// [RQ11] Interrupt enable reads zero in refresh mode
// [RQ12] Request high while flag and enable set
`ifndef DRF_DEFINES_SVH
`define DRF_DEFINES_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define DRF_ADDR_W 4
`define DRF_DATA_W 16
`define DRF_OFS_TIMING 4'h0
`define DRF_OFS_REFCTL 4'h2
`define DRF_OFS_ISTS 4'h4
`define DRF_OFS_IEN 4'h6
`define DRF_OFS_ICLR 4'h8

// ****************************************
// Field positions
// ****************************************
`define DRF_RCD_HI 9
`define DRF_RCD_LO 8
`define DRF_CKSP_BIT 3
`define DRF_RDXC_HI 1
`define DRF_RDXC_LO 0
`define DRF_CMF_BIT 15
`define DRF_COMPARE_MATCH_IRQ_ENABLE_BIT 14
`define DRF_REFRESH_ENABLE_BIT 7
`define DRF_EV_MATCH 0
`define DRF_EV_SUSP 1
`define DRF_EV_W 2

// ****************************************
// Reset values
// ****************************************
`define DRF_TIMING_RST 16'h0000
`define DRF_REFCTL_RST 16'h0000
`define DRF_EV_RST 2'h0
`define DRF_CNT_RST 2'h0

`endif

/* File: drf_pkg.sv */
// Types shared by the DRAM timing and refresh flag block
`include "drf_defines.svh"

package drf_pkg;

    // ****************************************
    // Register port request
    // ****************************************
    typedef struct packed {
        logic wr;                       // Write strobe
        logic rd;                       // Read strobe
        logic [`DRF_ADDR_W-1:0] addr;   // Byte address
        logic [`DRF_DATA_W-1:0] wdata;  // Write data
    } drf_bus_s;

    // ****************************************
    // Access sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        DRF_IDLE,    // Waiting for an access
        DRF_ROWCOL,  // Row-to-column waits
        DRF_SUSP     // Memory clock held
    } drf_state_e;

    // ****************************************
    // Whole block state
    // ****************************************
    typedef struct packed {
        drf_state_e st;                  // Sequencer state
        logic [1:0] cnt;                 // Wait / extension counter
        logic [`DRF_DATA_W-1:0] timing;  // Timing register
        logic [`DRF_DATA_W-1:0] refctl;  // Refresh control register
        logic cmf_armed;                 // Flag seen as 1 by a read
        logic match_d;                   // Match of last cycle
        logic [`DRF_DATA_W-1:0] rdata;   // Read data
        logic [`DRF_EV_W-1:0] ists;      // Sticky event status
        logic [`DRF_EV_W-1:0] ien;       // Event enables
    } drf_st_s;

endpackage : drf_pkg

/* File: drf_top.sv */
// DRAM access timing and refresh compare-match flag block
`include "drf_defines.svh"

module drf_top #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port
    input wire drf_pkg::drf_bus_s bus_req,
    output logic [`DRF_DATA_W-1:0] bus_rdata,
    // Access sequencing
    input wire logic row_strobe_start,
    output logic col_strobe_go,
    input wire logic single_addr_read,
    output logic clk_suspend,
    output logic seq_busy,
    // Refresh timer link
    input wire logic [CNT_W-1:0] refresh_counter,
    input wire logic [CNT_W-1:0] refresh_compare_value,
    input wire logic cbr_refresh_done,
    output logic refresh_enable,
    // Interrupts
    output logic compare_match_irq,
    output logic irq
);
    import drf_pkg::*;

    // ****************************************
    // State and decodes
    // ****************************************
    drf_st_s r_ff;       // Registered state
    drf_st_s nxt_r;      // Next state
    logic match;         // Counter equals compare value
    logic match_rise;    // First cycle of a match
    logic ref_en;        // Refresh mode selected
    logic compare_match_flag;           // Current flag
    logic compare_match_irq_enable;          // Current flag enable
    logic ras_ok;        // Row start accepted
    logic rd_ok;         // Single-address read accepted
    logic cksp;          // Suspend enable
    logic [1:0] rcd;     // Row-to-column wait code
    logic [1:0] rdxc;    // Extension code
    logic susp_done;     // Last suspended cycle
    logic wr_ref;        // Write to refresh control
    logic [`DRF_EV_W-1:0] ev; // Events this cycle

    // Field picks from the registered copy
    assign ref_en = r_ff.refctl[`DRF_REFRESH_ENABLE_BIT];
    assign compare_match_flag = r_ff.refctl[`DRF_CMF_BIT];
    assign compare_match_irq_enable = r_ff.refctl[`DRF_COMPARE_MATCH_IRQ_ENABLE_BIT];
    assign cksp = r_ff.timing[`DRF_CKSP_BIT];
    assign rcd = r_ff.timing[`DRF_RCD_HI:`DRF_RCD_LO];
    assign rdxc = r_ff.timing[`DRF_RDXC_HI:`DRF_RDXC_LO];

    // Counter and compare come from the same clock, no sync
    // [RQ6] Match detect
    assign match = (refresh_counter == refresh_compare_value);
    // Edge only, so a long match can still be cleared
    assign match_rise = match && !r_ff.match_d;

    // Requests are taken only when idle; others are dropped
    assign ras_ok = row_strobe_start && (r_ff.st == DRF_IDLE);
    // [RQ3] Suspend only when enabled
    assign rd_ok = single_addr_read && cksp && (r_ff.st == DRF_IDLE)
        && !row_strobe_start;
    assign susp_done = (r_ff.st == DRF_SUSP) && (r_ff.cnt == 2'h0);
    assign wr_ref = bus_req.wr && (bus_req.addr == `DRF_OFS_REFCTL);

    // Event vector for the status register
    always_comb begin
        ev = '0;
        ev[`DRF_EV_MATCH] = match_rise;
        ev[`DRF_EV_SUSP] = susp_done;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_r = r_ff;
        nxt_r.rdata = '0;
        nxt_r.match_d = match;

        // Timing register, plain storage
        // [RQ2] Reserved bits kept as storage
        if (bus_req.wr && bus_req.addr == `DRF_OFS_TIMING) begin
            nxt_r.timing = bus_req.wdata;
        end

        // Refresh control write
        if (wr_ref) begin
            // Low bits, refresh enable among them
            nxt_r.refctl[13:0] = bus_req.wdata[13:0];
            // [RQ11] Enable frozen in refresh mode
            if (!ref_en) begin
                nxt_r.refctl[`DRF_COMPARE_MATCH_IRQ_ENABLE_BIT] = bus_req.wdata[`DRF_COMPARE_MATCH_IRQ_ENABLE_BIT];
            end
            // [RQ7] Clear by zero after a read of one
            if (!bus_req.wdata[`DRF_CMF_BIT] && r_ff.cmf_armed && !ref_en) begin
                nxt_r.refctl[`DRF_CMF_BIT] = 1'b0;
            end
        end

        // [RQ11] Entering refresh mode drops the enable
        if (nxt_r.refctl[`DRF_REFRESH_ENABLE_BIT]) begin
            nxt_r.refctl[`DRF_COMPARE_MATCH_IRQ_ENABLE_BIT] = 1'b0;
        end

        // [RQ8] Refresh cycle clears the flag
        if (cbr_refresh_done && ref_en) begin
            nxt_r.refctl[`DRF_CMF_BIT] = 1'b0;
        end

        // Arming: a read that saw the flag set
        if (bus_req.rd && bus_req.addr == `DRF_OFS_REFCTL && compare_match_flag) begin
            nxt_r.cmf_armed = 1'b1;
        end

        // [RQ6] Set wins over any clear
        if (match_rise) begin
            nxt_r.refctl[`DRF_CMF_BIT] = 1'b1;
        end

        // A cleared flag must be read again before the next clear
        if (!nxt_r.refctl[`DRF_CMF_BIT]) begin
            nxt_r.cmf_armed = 1'b0;
        end

        // Interrupt enable and write-one clear
        if (bus_req.wr && bus_req.addr == `DRF_OFS_IEN) begin
            nxt_r.ien = bus_req.wdata[`DRF_EV_W-1:0];
        end
        if (bus_req.wr && bus_req.addr == `DRF_OFS_ICLR) begin
            nxt_r.ists = r_ff.ists & ~bus_req.wdata[`DRF_EV_W-1:0];
        end
        // Events land after the clear, so they are never lost
        nxt_r.ists = nxt_r.ists | ev;

        // Read data, stands one cycle after the strobe
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `DRF_OFS_TIMING: nxt_r.rdata = r_ff.timing;
                `DRF_OFS_REFCTL: nxt_r.rdata = r_ff.refctl;
                `DRF_OFS_ISTS: nxt_r.rdata = {14'h0000, r_ff.ists};
                `DRF_OFS_IEN: nxt_r.rdata = {14'h0000, r_ff.ien};
                // Clear register and holes read zero
                default: nxt_r.rdata = '0;
            endcase
        end

        // Access sequencer
        unique case (r_ff.st)
            DRF_IDLE: begin
                // [RQ1] Load row-to-column wait
                if (ras_ok) begin
                    nxt_r.st = DRF_ROWCOL;
                    nxt_r.cnt = rcd;
                end else if (rd_ok) begin
                    // [RQ4] Code n gives n+1 states
                    nxt_r.st = DRF_SUSP;
                    nxt_r.cnt = rdxc;
                end
            end
            DRF_ROWCOL: begin
                // [RQ1] Column strobe when waits run out
                if (r_ff.cnt == 2'h0) begin
                    nxt_r.st = DRF_IDLE;
                end else begin
                    nxt_r.cnt = r_ff.cnt - 2'h1;
                end
            end
            DRF_SUSP: begin
                // [RQ4] Hold clock for the count
                if (r_ff.cnt == 2'h0) begin
                    nxt_r.st = DRF_IDLE;
                end else begin
                    nxt_r.cnt = r_ff.cnt - 2'h1;
                end
            end
            // Code 3 is never loaded; an upset there falls back to idle
            default: begin
                nxt_r.st = DRF_IDLE;
                nxt_r.cnt = `DRF_CNT_RST;
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            r_ff.st <= DRF_IDLE;
            r_ff.cnt <= `DRF_CNT_RST;
            r_ff.timing <= `DRF_TIMING_RST;
            r_ff.refctl <= `DRF_REFCTL_RST;
            r_ff.cmf_armed <= 1'b0;
            r_ff.match_d <= 1'b0;
            r_ff.rdata <= '0;
            r_ff.ists <= `DRF_EV_RST;
            r_ff.ien <= `DRF_EV_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign bus_rdata = r_ff.rdata;
    // [RQ1] Column strobe cycle
    assign col_strobe_go = (r_ff.st == DRF_ROWCOL) && (r_ff.cnt == 2'h0);
    // [RQ5] Extension counted only in suspend state
    assign clk_suspend = (r_ff.st == DRF_SUSP);
    assign seq_busy = (r_ff.st != DRF_IDLE);
    // [RQ10] Mode select to the refresh engine
    assign refresh_enable = ref_en;
    // [RQ9] Enable gates the flag
    // [RQ12] Level request while both set
    assign compare_match_irq = compare_match_flag && compare_match_irq_enable;
    assign irq = |(r_ff.ists & r_ff.ien);

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Accepted row starts and extension requests
    sequence s_row0;
        ras_ok && rcd == 2'b00;
    endsequence
    sequence s_row3;
        ras_ok && rcd == 2'b11;
    endsequence
    sequence s_susp4;
        rd_ok && rdxc == 2'b11;
    endsequence
    sequence s_row1;
        ras_ok && rcd == 2'b01;
    endsequence
    sequence s_susp1;
        rd_ok && rdxc == 2'b00;
    endsequence

    a_rowcol_nowait: assert property ( // [RQ1]
        s_row0 |=> col_strobe_go)
        else $error("column strobe not next after zero wait");
    a_rowcol_three: assert property ( // [RQ1]
        s_row3 |=> !col_strobe_go [*3] ##1 col_strobe_go)
        else $error("three waits not inserted");
    a_susp_off: assert property ( // [RQ3]
        (single_addr_read && !cksp) |=> !clk_suspend)
        else $error("suspend while disabled");
    a_susp_four: assert property ( // [RQ4]
        s_susp4 |=> clk_suspend [*4] ##1 !clk_suspend)
        else $error("four extension states not held");
    a_flag_set: assert property ( // [RQ6]
        match_rise |=> compare_match_flag)
        else $error("match did not set flag");
    a_flag_w1: assert property ( // [RQ7]
        (wr_ref && bus_req.wdata[`DRF_CMF_BIT] && compare_match_flag && !cbr_refresh_done) |=> compare_match_flag)
        else $error("writing one cleared flag");
    a_flag_cbr: assert property ( // [RQ8]
        (cbr_refresh_done && ref_en && !match_rise) |=> !compare_match_flag)
        else $error("refresh did not clear flag");
    a_timer_keep: assert property ( // [RQ10]
        (cbr_refresh_done && !ref_en && compare_match_flag && !wr_ref) |=> compare_match_flag)
        else $error("refresh cleared flag in timer mode");
    a_irq_gate: assert property ( // [RQ9]
        !compare_match_irq_enable |-> !compare_match_irq)
        else $error("request while enable clear");
    a_compare_match_irq_enable_zero: assert property ( // [RQ11]
        $past(ref_en) && ref_en |-> !compare_match_irq_enable)
        else $error("enable set in refresh mode");
    a_irq_hold: assert property ( // [RQ12]
        (compare_match_flag && compare_match_irq_enable && !cbr_refresh_done && !wr_ref) |=> compare_match_irq)
        else $error("request dropped while flag held");

    // One-wait and one-state settings, the refused extension request, enable gating, flag hold and mode output
    a_rowcol_one: assert property ( // [RQ1]
        s_row1 |=> !col_strobe_go ##1 col_strobe_go)
        else $error("one wait not inserted");

    a_susp_one: assert property ( // [RQ4]
        s_susp1 |=> clk_suspend ##1 !clk_suspend)
        else $error("single extension state not held");

    a_ext_ignored: assert property ( // [RQ5]
        (single_addr_read && !row_strobe_start && !cksp && !seq_busy) |=> !seq_busy)
        else $error("extension started while suspend disabled");

    a_irq_blocked: assert property ( // [RQ9]
        (wr_ref && !ref_en && !bus_req.wdata[`DRF_COMPARE_MATCH_IRQ_ENABLE_BIT]) |=> !compare_match_irq)
        else $error("request after enable cleared");

    a_flag_hold: assert property ( // [RQ7]
        (compare_match_flag && !wr_ref && !cbr_refresh_done) |=> compare_match_flag)
        else $error("flag lost without a clear");

    a_refen_out: assert property ( // [RQ10]
        wr_ref |=> (refresh_enable == $past(bus_req.wdata[`DRF_REFRESH_ENABLE_BIT])))
        else $error("refresh enable not taken from write");

endmodule : drf_top

/* File: drf_mem_model.sv */
// Memory-side model that times column strobes and held-clock cycles
module drf_mem_model (
    // Clock
    input wire logic core_clk,
    // Access events seen by the memory
    input wire logic row_strobe_start,
    input wire logic single_addr_read,
    input wire logic col_strobe_go,
    input wire logic clk_suspend,
    // Measured figures for the bench
    output logic [7:0] col_lat,
    output logic [7:0] susp_cnt
);
    logic [7:0] t = 8'h00; // Cycles since the access began

    // ****************************************
    // Measurement
    // ****************************************
    // Each new access restarts both figures, so a stale one cannot pass
    always @(posedge core_clk) begin
        if (row_strobe_start || single_addr_read) begin
            t <= 8'h00;
            col_lat <= 8'h00;
            susp_cnt <= 8'h00;
        end else begin
            t <= t + 8'h01;
            if (col_strobe_go) col_lat <= t + 8'h01;
            if (clk_suspend) susp_cnt <= susp_cnt + 8'h01;
        end
    end
endmodule : drf_mem_model

/* File: drf_top_tb_top.sv */
// Self-checking bench of the DRAM timing and refresh flag block
`include "drf_defines.svh"

module drf_top_tb_top;
    import drf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [15:0] timing; // Timing register value
        logic is_row;        // Row start, else extension request
        logic [7:0] lat;     // Expected column strobe distance
        logic [7:0] susp;    // Expected held-clock cycles
    } drf_tb_row_s;

    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    drf_bus_s bus_req = '0;
    logic [15:0] bus_rdata;
    logic row_strobe_start = 1'b0;
    logic single_addr_read = 1'b0;
    logic col_strobe_go, clk_suspend, seq_busy, refresh_enable, compare_match_irq, irq;
    logic [15:0] refresh_counter = 16'h0000;
    logic [15:0] refresh_compare_value = 16'h0001;
    logic cbr_refresh_done = 1'b0;
    logic [7:0] col_lat, susp_cnt;
    int bad_count = 0;
    int checks = 0;
    drf_tb_row_s rows [9] = '{
        '{16'h0000, 1'b1, 8'h01, 8'h00}, '{16'h0100, 1'b1, 8'h02, 8'h00},
        '{16'h0200, 1'b1, 8'h03, 8'h00}, '{16'h0300, 1'b1, 8'h04, 8'h00},
        '{16'h0008, 1'b0, 8'h00, 8'h01}, '{16'h0009, 1'b0, 8'h00, 8'h02},
        '{16'h000A, 1'b0, 8'h00, 8'h03}, '{16'h000B, 1'b0, 8'h00, 8'h04},
        '{16'h0003, 1'b0, 8'h00, 8'h00}};

    // 125 MHz clock
    always #4 core_clk = ~core_clk;

    drf_top #(.CNT_W(16)) u_drf_top (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .row_strobe_start(row_strobe_start),
        .col_strobe_go(col_strobe_go), .single_addr_read(single_addr_read),
        .clk_suspend(clk_suspend), .seq_busy(seq_busy), .refresh_counter(refresh_counter),
        .refresh_compare_value(refresh_compare_value), .cbr_refresh_done(cbr_refresh_done),
        .refresh_enable(refresh_enable), .compare_match_irq(compare_match_irq), .irq(irq));

    drf_mem_model u_drf_mem_model (.core_clk(core_clk), .row_strobe_start(row_strobe_start),
        .single_addr_read(single_addr_read), .col_strobe_go(col_strobe_go),
        .clk_suspend(clk_suspend), .col_lat(col_lat), .susp_cnt(susp_cnt));

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk16

    task automatic chk1(input string n, input logic e, input logic s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %b seen %b", n, e, s);
        end
    endtask : chk1

    // Trailing idle edge keeps two strobes from landing in one step
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus_req <= '0;
        @(posedge core_clk);
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge core_clk);
        bus_req <= '0;
        #1 d = bus_rdata;
        @(posedge core_clk);
    endtask : bus_rd

    task automatic rd_chk(input string n, input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        bus_rd(a, d);
        chk16(n, e, d);
    endtask : rd_chk

    // One cycle of counter equal to compare value
    task automatic match_pulse();
        refresh_compare_value <= 16'h0000;
        @(posedge core_clk);
        refresh_compare_value <= 16'h0001;
        repeat (3) @(posedge core_clk);
    endtask : match_pulse

    task automatic tally_and_finish();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // Watchdog far beyond the expected run
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1 chk1("irq", 1'b0, irq);
        chk1("refresh_enable", 1'b0, refresh_enable);
        // Realign so every drive lands on a rising edge
        @(posedge core_clk);
        rd_chk("timing", `DRF_OFS_TIMING, 16'h0000);
        rd_chk("refctl", `DRF_OFS_REFCTL, 16'h0000);
        rd_chk("unmapped", 4'hE, 16'h0000);
        // Ordinary sequencer cases
        foreach (rows[i]) begin
            bus_wr(`DRF_OFS_TIMING, rows[i].timing);
            rd_chk("timing", `DRF_OFS_TIMING, rows[i].timing);
            if (rows[i].is_row) row_strobe_start <= 1'b1;
            else single_addr_read <= 1'b1;
            @(posedge core_clk);
            row_strobe_start <= 1'b0;
            single_addr_read <= 1'b0;
            #1 chk1("seq_busy", rows[i].is_row || rows[i].susp != 8'h00, seq_busy);
            repeat (8) @(posedge core_clk);
            chk16("col_lat", {8'h00, rows[i].lat}, {8'h00, col_lat});
            chk16("susp_cnt", {8'h00, rows[i].susp}, {8'h00, susp_cnt});
        end
        // Row start wins over an extension request in the same cycle
        bus_wr(`DRF_OFS_TIMING, 16'h0309);
        row_strobe_start <= 1'b1;
        single_addr_read <= 1'b1;
        @(posedge core_clk);
        row_strobe_start <= 1'b0;
        single_addr_read <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk16("col_lat", 16'h0004, {8'h00, col_lat});
        chk16("susp_cnt", 16'h0000, {8'h00, susp_cnt});
        rd_chk("status", `DRF_OFS_ISTS, 16'h0002);
        bus_wr(`DRF_OFS_ICLR, 16'h0003);
        // Interval timer mode: flag, enable and clearing
        bus_wr(`DRF_OFS_REFCTL, 16'h4000);
        bus_wr(`DRF_OFS_IEN, 16'h0001);
        match_pulse();
        #1 chk1("compare_match_irq", 1'b1, compare_match_irq);
        chk1("irq", 1'b1, irq);
        @(posedge core_clk);
        bus_wr(`DRF_OFS_REFCTL, 16'h4000);
        rd_chk("refctl", `DRF_OFS_REFCTL, 16'hC000);
        bus_wr(`DRF_OFS_REFCTL, 16'hC000);
        rd_chk("refctl", `DRF_OFS_REFCTL, 16'hC000);
        bus_wr(`DRF_OFS_REFCTL, 16'h4000);
        rd_chk("refctl", `DRF_OFS_REFCTL, 16'h4000);
        #1 chk1("compare_match_irq", 1'b0, compare_match_irq);
        @(posedge core_clk);
        rd_chk("status", `DRF_OFS_ISTS, 16'h0001);
        bus_wr(`DRF_OFS_IEN, 16'h0000);
        #1 chk1("irq", 1'b0, irq);
        @(posedge core_clk);
        bus_wr(`DRF_OFS_ICLR, 16'h0001);
        rd_chk("status", `DRF_OFS_ISTS, 16'h0000);
        // Refresh mode: enable forced low, refresh clears flag
        bus_wr(`DRF_OFS_REFCTL, 16'h4080);
        rd_chk("refctl", `DRF_OFS_REFCTL, 16'h0080);
        #1 chk1("refresh_enable", 1'b1, refresh_enable);
        @(posedge core_clk);
        match_pulse();
        rd_chk("refctl", `DRF_OFS_REFCTL, 16'h8080);
        bus_wr(`DRF_OFS_REFCTL, 16'h4080);
        rd_chk("refctl", `DRF_OFS_REFCTL, 16'h8080);
        #1 chk1("compare_match_irq", 1'b0, compare_match_irq);
        @(posedge core_clk);
        cbr_refresh_done <= 1'b1;
        @(posedge core_clk);
        cbr_refresh_done <= 1'b0;
        @(posedge core_clk);
        rd_chk("refctl", `DRF_OFS_REFCTL, 16'h0080);
        // Mid-run reset returns both registers and the mode to zero
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1 chk1("refresh_enable", 1'b0, refresh_enable);
        chk1("compare_match_irq", 1'b0, compare_match_irq);
        @(posedge core_clk);
        rd_chk("timing", `DRF_OFS_TIMING, 16'h0000);
        rd_chk("refctl", `DRF_OFS_REFCTL, 16'h0000);
        tally_and_finish();
    end
endmodule : drf_top_tb_top
